// [verilog/split_status_pkg.sv]
// constants for the split status and bridge identity registers
package split_status_pkg;
  localparam logic [7:0] SEC_STAT_OFS = 8'h80;
  localparam logic [7:0] BRG_STAT_OFS = 8'h84;
  localparam logic [1:0] ADDR_LOW_ZERO = 2'h0;

  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;

  localparam int AD_TYPE_HI = 1;
  localparam int AD_TYPE_LO = 0;
  localparam int AD_REG_HI  = 7;
  localparam int AD_REG_LO  = 2;
  localparam int AD_FUNC_HI = 10;
  localparam int AD_FUNC_LO = 8;
  localparam int AD_DEV_HI  = 15;
  localparam int AD_DEV_LO  = 11;

  localparam int UNEXP_BIT = 19;
  localparam int OVRN_BIT  = 20;
  localparam int DLY_BIT   = 21;
  localparam int FREQ_HI   = 24;
  localparam int FREQ_LO   = 22;
  localparam int RSVD_HI   = 31;
  localparam int RSVD_LO   = 25;
  localparam int W1C_LANE  = 2;

  localparam int FUNC_HI = 2;
  localparam int FUNC_LO = 0;
  localparam int DEV_HI  = 7;
  localparam int DEV_LO  = 3;
  localparam int BUS_HI  = 15;
  localparam int BUS_LO  = 8;

  localparam logic [4:0]  DEV_RST    = 5'h1F;
  localparam logic [2:0]  FUNC_RST   = 3'h0;
  localparam logic [7:0]  BUS_RST    = 8'h00;
  localparam logic [15:0] CPL_ID_RST = {BUS_RST, DEV_RST, FUNC_RST};

  localparam logic [2:0] FREQ_CONV = 3'h0;
  localparam logic [2:0] FREQ_66   = 3'h1;
  localparam logic [2:0] FREQ_133  = 3'h2;
endpackage

// [verilog/sticky_flag.sv]
// one write-one-to-clear status flag, set beats clear
`timescale 1ns/1ns
module sticky_flag (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic allow,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  typedef struct packed {
    logic q;
  } state_s;

  state_s state_reg;
  state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (!allow) begin
      state_next.q = 1'b0;
    end else if (set) begin
      state_next.q = 1'b1;
    end else if (clr) begin
      state_next.q = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.q;

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
      allow && set |=> q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag missed a set");

  property p_w1c;
    @(posedge clk) disable iff (!rst_n)
      allow && clr && !set |=> !q;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by write one");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      allow && !set && !clr |=> q == $past(q);
  endproperty
  a_hold: assert property (p_hold) else $error("flag changed without cause");
endmodule

// [verilog/cfg_target_match.sv]
// config write decode and capture of device and function numbers
`timescale 1ns/1ns
module cfg_target_match (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        valid,
  input  wire logic [3:0]  cmd,
  input  wire logic        idsel,
  input  wire logic [31:0] ad,
  input  wire logic [2:0]  func_num,
  output logic             hit_wr,
  output logic             hit_rd,
  output logic [4:0]       dev_num,
  output logic [2:0]       func_fld
);
  typedef struct packed {
    logic [4:0] dev;
    logic [2:0] func;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic   target;

  localparam int AD_TYPE_HI = split_status_pkg::AD_TYPE_HI;
  localparam int AD_TYPE_LO = split_status_pkg::AD_TYPE_LO;
  localparam int AD_FUNC_HI = split_status_pkg::AD_FUNC_HI;
  localparam int AD_FUNC_LO = split_status_pkg::AD_FUNC_LO;
  localparam int AD_DEV_HI  = split_status_pkg::AD_DEV_HI;
  localparam int AD_DEV_LO  = split_status_pkg::AD_DEV_LO;

  // common address-phase qualification for both directions
  assign target = valid && idsel
                  && (ad[AD_TYPE_HI:AD_TYPE_LO] == split_status_pkg::ADDR_LOW_ZERO)
                  && (ad[AD_FUNC_HI:AD_FUNC_LO] == func_num);
  assign hit_wr = target && (cmd == split_status_pkg::CMD_CFG_WR);
  assign hit_rd = target && (cmd == split_status_pkg::CMD_CFG_RD);

  always_comb begin
    state_next = state_reg;
    if (hit_wr) begin
      state_next.dev  = ad[AD_DEV_HI:AD_DEV_LO];
      state_next.func = ad[AD_FUNC_HI:AD_FUNC_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.dev  <= split_status_pkg::DEV_RST;
      state_reg.func <= split_status_pkg::FUNC_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dev_num  = state_reg.dev;
  assign func_fld = state_reg.func;

  property p_dev_cap;
    @(posedge clk) disable iff (!rst_n)
      hit_wr |=> dev_num == $past(ad[AD_DEV_HI:AD_DEV_LO]);
  endproperty
  a_dev_cap: assert property (p_dev_cap) else $error("device number not captured");

  property p_hit_qual;
    @(posedge clk) disable iff (!rst_n)
      hit_wr |-> valid && idsel && cmd == split_status_pkg::CMD_CFG_WR
                 && ad[AD_TYPE_HI:AD_TYPE_LO] == split_status_pkg::ADDR_LOW_ZERO
                 && ad[AD_FUNC_HI:AD_FUNC_LO] == func_num;
  endproperty
  a_hit_qual: assert property (p_hit_qual) else $error("write accepted without match");
endmodule

// [verilog/bridge_split_status_regs.sv]
// split transaction status and bridge identity register bank
`timescale 1ns/1ns
// Function
// - own-ID split completion sets unexpected flag
// - unexpected flag zero in forward mode
// - buffer-full split completion end sets overrun
// - no commitment room sets delayed flag
// - clock code: conventional 0, 66 1, 133 2
// - clock code reads zero in reverse mode
// - function field from address bits ten-eight
// - addressed write captures device number, reset ones
// - addressed: cfg write, IDSEL, type0, function
// - bus field mirrors primary bus number
// - completer ID from bus, device, function
// - same ID used in mixed bus modes
module bridge_split_status_regs #(
  parameter logic [2:0] FUNC_NUM = 3'h0
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        REVERSE_MODE,
  input  wire logic        SEC_PCIX,
  input  wire logic        SEC_M66,
  input  wire logic        CFG_VALID,
  input  wire logic [3:0]  CFG_CMD,
  input  wire logic        CFG_IDSEL,
  input  wire logic [31:0] CFG_AD,
  input  wire logic [31:0] CFG_WDATA,
  input  wire logic [3:0]  CFG_BE,
  output logic [31:0]      CFG_RDATA,
  output logic             CFG_RVALID,
  input  wire logic [7:0]  PRI_BUS_NUM,
  input  wire logic        UCPL_EVT,
  input  wire logic [15:0] UCPL_REQ_ID,
  input  wire logic        OVRN_EVT,
  input  wire logic        SDLY_EVT,
  output logic [15:0]      CPL_ID
);
  localparam int UNEXP_BIT = split_status_pkg::UNEXP_BIT;
  localparam int OVRN_BIT  = split_status_pkg::OVRN_BIT;
  localparam int DLY_BIT   = split_status_pkg::DLY_BIT;
  localparam int FREQ_HI   = split_status_pkg::FREQ_HI;
  localparam int FREQ_LO   = split_status_pkg::FREQ_LO;
  localparam int RSVD_HI   = split_status_pkg::RSVD_HI;
  localparam int RSVD_LO   = split_status_pkg::RSVD_LO;
  localparam int W1C_LANE  = split_status_pkg::W1C_LANE;
  localparam int FUNC_HI   = split_status_pkg::FUNC_HI;
  localparam int FUNC_LO   = split_status_pkg::FUNC_LO;
  localparam int DEV_HI    = split_status_pkg::DEV_HI;
  localparam int DEV_LO    = split_status_pkg::DEV_LO;
  localparam int BUS_HI    = split_status_pkg::BUS_HI;
  localparam int BUS_LO    = split_status_pkg::BUS_LO;
  localparam int AD_REG_HI = split_status_pkg::AD_REG_HI;
  localparam int AD_REG_LO = split_status_pkg::AD_REG_LO;
  localparam int AD_DEV_HI = split_status_pkg::AD_DEV_HI;
  localparam int AD_DEV_LO = split_status_pkg::AD_DEV_LO;

  typedef struct packed {
    logic        rev_s1;
    logic        rev_s2;
    logic        pcix_s1;
    logic        pcix_s2;
    logic        m66_s1;
    logic        m66_s2;
    logic [31:0] rdata;
    logic        rvalid;
    logic [15:0] cpl_id;
  } state_s;

  state_s      state_reg;
  state_s      state_next;

  logic        hit_wr;
  logic        hit_rd;
  logic [4:0]  dev_num;
  logic [2:0]  func_fld;
  logic [7:0]  reg_ofs;
  logic        sel_sec;
  logic        sel_brg;
  logic        wr_sec;
  logic        rd_sec;
  logic        rd_brg;
  logic [15:0] own_id;
  logic        id_match;
  logic        unexp_q;
  logic        ovrn_q;
  logic        dly_q;
  logic        unexp_clr;
  logic        ovrn_clr;
  logic        dly_clr;
  logic [2:0]  freq_code;
  logic [31:0] sec_word;
  logic [31:0] brg_word;

  cfg_target_match u_match (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .valid    (CFG_VALID),
    .cmd      (CFG_CMD),
    .idsel    (CFG_IDSEL),
    .ad       (CFG_AD),
    .func_num (FUNC_NUM),
    .hit_wr   (hit_wr),
    .hit_rd   (hit_rd),
    .dev_num  (dev_num),
    .func_fld (func_fld)
  );

  // dword offset decode of the addressed register
  assign reg_ofs = {CFG_AD[AD_REG_HI:AD_REG_LO], 2'h0};
  assign sel_sec = (reg_ofs == split_status_pkg::SEC_STAT_OFS);
  assign sel_brg = (reg_ofs == split_status_pkg::BRG_STAT_OFS);
  assign wr_sec  = hit_wr && sel_sec && CFG_BE[W1C_LANE];
  assign rd_sec  = hit_rd && sel_sec;
  assign rd_brg  = hit_rd && sel_brg;

  // own requester identity, used for matching and as completer ID
  assign own_id   = {PRI_BUS_NUM, dev_num, func_fld};
  assign id_match = UCPL_EVT && (UCPL_REQ_ID == own_id);

  assign unexp_clr = wr_sec && CFG_WDATA[UNEXP_BIT];
  assign ovrn_clr  = wr_sec && CFG_WDATA[OVRN_BIT];
  assign dly_clr   = wr_sec && CFG_WDATA[DLY_BIT];

  // only reverse mode lets this flag live
  sticky_flag u_unexp (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .allow (state_reg.rev_s2),
    .set   (id_match),
    .clr   (unexp_clr),
    .q     (unexp_q)
  );

  sticky_flag u_ovrn (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .allow (1'b1),
    .set   (OVRN_EVT),
    .clr   (ovrn_clr),
    .q     (ovrn_q)
  );

  sticky_flag u_dly (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .allow (1'b1),
    .set   (SDLY_EVT),
    .clr   (dly_clr),
    .q     (dly_q)
  );

  // secondary bus strap encode; no reserved code can be produced
  always_comb begin
    if (state_reg.rev_s2) begin
      freq_code = split_status_pkg::FREQ_CONV;
    end else if (!state_reg.pcix_s2) begin
      freq_code = split_status_pkg::FREQ_CONV;
    end else if (state_reg.m66_s2) begin
      freq_code = split_status_pkg::FREQ_66;
    end else begin
      freq_code = split_status_pkg::FREQ_133;
    end
  end

  // lower half of the secondary word lives outside this bank
  always_comb begin
    sec_word                  = '0;
    sec_word[UNEXP_BIT]       = unexp_q;
    sec_word[OVRN_BIT]        = ovrn_q;
    sec_word[DLY_BIT]         = dly_q;
    sec_word[FREQ_HI:FREQ_LO] = freq_code;
  end

  // upper half of this word is primary status, not held here
  always_comb begin
    brg_word                  = '0;
    brg_word[FUNC_HI:FUNC_LO] = func_fld;
    brg_word[DEV_HI:DEV_LO]   = dev_num;
    brg_word[BUS_HI:BUS_LO]   = PRI_BUS_NUM;
  end

  always_comb begin
    state_next         = state_reg;
    state_next.rev_s1  = REVERSE_MODE;
    state_next.rev_s2  = state_reg.rev_s1;
    state_next.pcix_s1 = SEC_PCIX;
    state_next.pcix_s2 = state_reg.pcix_s1;
    state_next.m66_s1  = SEC_M66;
    state_next.m66_s2  = state_reg.m66_s1;
    state_next.rvalid  = hit_rd;
    if (rd_sec) begin
      state_next.rdata = sec_word;
    end else if (rd_brg) begin
      state_next.rdata = brg_word;
    end else if (hit_rd) begin
      state_next.rdata = '0;
    end
    // refreshed every cycle so a completion or a mixed-mode
    // transfer sees newly captured numbers one cycle after they change
    state_next.cpl_id  = own_id;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg        <= '0;
      state_reg.cpl_id <= split_status_pkg::CPL_ID_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign CFG_RDATA  = state_reg.rdata;
  assign CFG_RVALID = state_reg.rvalid;
  assign CPL_ID     = state_reg.cpl_id;

  property p_unexp_set;
    @(posedge CORE_CLK) disable iff (!RST_N)
      id_match && state_reg.rev_s2 && state_next.rev_s2 |=> unexp_q;
  endproperty
  a_unexp_set: assert property (p_unexp_set) else $error("unexpected flag not set");

  property p_unexp_fwd;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !state_reg.rev_s2 |=> !unexp_q;
  endproperty
  a_unexp_fwd: assert property (p_unexp_fwd) else $error("unexpected flag set forward");

  property p_ovrn;
    @(posedge CORE_CLK) disable iff (!RST_N)
      OVRN_EVT |=> ovrn_q;
  endproperty
  a_ovrn: assert property (p_ovrn) else $error("overrun flag not set");

  property p_dly;
    @(posedge CORE_CLK) disable iff (!RST_N)
      SDLY_EVT |=> dly_q;
  endproperty
  a_dly: assert property (p_dly) else $error("delayed flag not set");

  property p_freq;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !state_reg.rev_s2 && state_reg.pcix_s2
      |-> freq_code == (state_reg.m66_s2 ? split_status_pkg::FREQ_66
                                         : split_status_pkg::FREQ_133);
  endproperty
  a_freq: assert property (p_freq) else $error("clock code wrong");

  property p_freq_rev;
    @(posedge CORE_CLK) disable iff (!RST_N)
      rd_sec && state_reg.rev_s2
      |=> CFG_RVALID && CFG_RDATA[FREQ_HI:FREQ_LO] == split_status_pkg::FREQ_CONV;
  endproperty
  a_freq_rev: assert property (p_freq_rev) else $error("clock code not zero");

  property p_func_rd;
    @(posedge CORE_CLK) disable iff (!RST_N)
      rd_brg |=> CFG_RDATA[FUNC_HI:FUNC_LO] == $past(func_fld);
  endproperty
  a_func_rd: assert property (p_func_rd) else $error("function field wrong");

  property p_bus_rd;
    @(posedge CORE_CLK) disable iff (!RST_N)
      rd_brg |=> CFG_RDATA[BUS_HI:BUS_LO] == $past(PRI_BUS_NUM);
  endproperty
  a_bus_rd: assert property (p_bus_rd) else $error("bus field wrong");

  property p_rsvd;
    @(posedge CORE_CLK) disable iff (!RST_N)
      rd_sec |=> CFG_RDATA[RSVD_HI:RSVD_LO] == 7'h00 && CFG_RDATA[BUS_HI:FUNC_LO] == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  property p_cpl_id;
    @(posedge CORE_CLK) disable iff (!RST_N)
      hit_wr ##1 !hit_wr |=> CPL_ID[DEV_HI:DEV_LO] == $past(CFG_AD[AD_DEV_HI:AD_DEV_LO], 2);
  endproperty
  a_cpl_id: assert property (p_cpl_id) else $error("completer ID stale");

  property p_w1c_top;
    @(posedge CORE_CLK) disable iff (!RST_N)
      ovrn_clr && !OVRN_EVT |=> !ovrn_q;
  endproperty
  a_w1c_top: assert property (p_w1c_top) else $error("overrun flag not cleared");

  property p_dly_clr;
    @(posedge CORE_CLK) disable iff (!RST_N)
      dly_clr && !SDLY_EVT |=> !dly_q;
  endproperty
  a_dly_clr: assert property (p_dly_clr) else $error("delayed flag not cleared");

  // answer exactly one cycle after the taking edge, never without a hit
  property p_rvalid;
    @(posedge CORE_CLK) disable iff (!RST_N)
      hit_rd |=> CFG_RVALID;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");

  property p_rvalid_once;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !hit_rd |=> !CFG_RVALID;
  endproperty
  a_rvalid_once: assert property (p_rvalid_once) else $error("read answer unasked");

  property p_brg_upper;
    @(posedge CORE_CLK) disable iff (!RST_N)
      rd_brg |=> CFG_RDATA[RSVD_HI:BUS_HI+1] == 16'h0000;
  endproperty
  a_brg_upper: assert property (p_brg_upper) else $error("identity upper half not zero");

  property p_unmapped;
    @(posedge CORE_CLK) disable iff (!RST_N)
      hit_rd && !sel_sec && !sel_brg |=> CFG_RDATA == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// [verification/cfg_requester.sv]
// configuration requester and split event source facing the bridge
`timescale 1ns/1ns
module cfg_requester (
  input  wire logic        clk,
  output logic             valid,
  output logic [3:0]       cmd,
  output logic             idsel,
  output logic [31:0]      ad,
  output logic [31:0]      wdata,
  output logic [3:0]       be,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  output logic             ucpl,
  output logic [15:0]      ucpl_id,
  output logic             ovrn,
  output logic             sdly
);
  initial begin
    valid = 1'b0;
    cmd = 4'h0;
    idsel = 1'b0;
    ad = 32'h0;
    wdata = 32'h0;
    be = 4'h0;
    ucpl = 1'b0;
    ucpl_id = 16'h0;
    ovrn = 1'b0;
    sdly = 1'b0;
  end

  // single-cycle address phase; idle lines other than be go inverted so stale values never match
  task automatic access(input logic [3:0] c, input logic sel, input logic [31:0] a,
                        input logic [31:0] d, input logic [3:0] b,
                        output logic got, output logic [31:0] q);
    @(negedge clk);
    valid = 1'b1;
    cmd = c;
    idsel = sel;
    ad = a;
    wdata = d;
    be = b;
    @(negedge clk);
    // the answer stands only in the cycle after the taking edge
    got = rvalid;
    q = rdata;
    valid = 1'b0;
    cmd = ~c;
    idsel = ~sel;
    ad = ~a;
    wdata = ~d;
  endtask

  // which: bit0 unexpected completion, bit1 overrun, bit2 delayed request
  task automatic pulse(input logic [2:0] which, input logic [15:0] id);
    @(negedge clk);
    ucpl = which[0];
    ovrn = which[1];
    sdly = which[2];
    ucpl_id = id;
    @(negedge clk);
    ucpl = 1'b0;
    ovrn = 1'b0;
    sdly = 1'b0;
    ucpl_id = ~id;
  endtask
endmodule

// [verification/tb.sv]
// self-checking bench for the split status and bridge identity registers
`timescale 1ns/1ns
module tb;
  localparam logic [2:0] FN = 3'h5;
  logic        clk;
  logic        rst_n;
  logic        rev;
  logic        pcix;
  logic        m66;
  logic [7:0]  bus;
  logic        valid;
  logic [3:0]  cmd;
  logic        idsel;
  logic [31:0] ad;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        rvalid;
  logic        ucpl;
  logic [15:0] ucpl_id;
  logic        ovrn;
  logic        sdly;
  logic [15:0] cpl_id;
  int          fails = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  bridge_split_status_regs #(.FUNC_NUM(FN)) i_bridge_split_status_regs (
    .CORE_CLK(clk), .RST_N(rst_n), .REVERSE_MODE(rev), .SEC_PCIX(pcix), .SEC_M66(m66),
    .CFG_VALID(valid), .CFG_CMD(cmd), .CFG_IDSEL(idsel), .CFG_AD(ad), .CFG_WDATA(wdata),
    .CFG_BE(be), .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .PRI_BUS_NUM(bus),
    .UCPL_EVT(ucpl), .UCPL_REQ_ID(ucpl_id), .OVRN_EVT(ovrn), .SDLY_EVT(sdly), .CPL_ID(cpl_id));

  cfg_requester i_cfg_requester (
    .clk(clk), .valid(valid), .cmd(cmd), .idsel(idsel), .ad(ad), .wdata(wdata), .be(be),
    .rdata(rdata), .rvalid(rvalid), .ucpl(ucpl), .ucpl_id(ucpl_id), .ovrn(ovrn), .sdly(sdly));

  function automatic logic [31:0] adr(input logic [4:0] dev, input logic [2:0] fn,
                                      input logic [7:0] ofs);
    return {16'h0000, dev, fn, ofs};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [31:0] exp, input string what);
    logic        got;
    logic [31:0] q;
    i_cfg_requester.access(split_status_pkg::CMD_CFG_RD, 1'b1, adr(5'h09, FN, ofs),
                           32'h0, 4'h0, got, q);
    check({what, " rvalid"}, 32'h1, {31'h0, got});
    check(what, exp, q);
  endtask

  // always addresses the bridge as device 9, so the captured number stays known
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d, input logic [3:0] b);
    logic        got;
    logic [31:0] q;
    i_cfg_requester.access(split_status_pkg::CMD_CFG_WR, 1'b1, adr(5'h09, FN, ofs), d, b,
                           got, q);
  endtask

  task automatic set_mode(input logic r, input logic p, input logic m);
    @(negedge clk);
    rev = r;
    pcix = p;
    m66 = m;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_reset;
    check("cpl_id reset", {16'h0, bus, 5'h1F, 3'h0}, {16'h0, cpl_id});
    rd(8'h84, {16'h0, bus, 5'h1F, 3'h0}, "ident reset");
    rd(8'h80, 32'h0, "status reset");
    rd(8'h88, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_capture;
    logic        got;
    logic [31:0] q;
    logic [31:0] a;
    wr(8'h84, 32'hFFFF_FFFF, 4'hF);
    rd(8'h84, {16'h0, bus, 5'h09, FN}, "ident capture");
    check("cpl_id capture", {16'h0, bus, 5'h09, FN}, {16'h0, cpl_id});
    // no idsel, read command, type 1, wrong function: none may capture
    for (int i = 0; i < 4; i++) begin
      a = adr(5'(i + 16), (i == 3) ? (FN ^ 3'h1) : FN, 8'h84);
      if (i == 2) begin
        a[1:0] = 2'h1;
      end
      i_cfg_requester.access((i == 1) ? split_status_pkg::CMD_CFG_RD
                             : split_status_pkg::CMD_CFG_WR, i != 0, a, 32'h0, 4'hF, got, q);
      rd(8'h84, {16'h0, bus, 5'h09, FN}, "ident refused");
    end
    @(negedge clk);
    bus = 8'hA7;
    repeat (3) @(negedge clk);
    rd(8'h84, {16'h0, 8'hA7, 5'h09, FN}, "ident bus");
    check("cpl_id bus", {16'h0, 8'hA7, 5'h09, FN}, {16'h0, cpl_id});
    $display("test capture done");
  endtask

  task automatic t_freq;
    logic [2:0] m;
    logic [2:0] code;
    for (int i = 0; i < 6; i++) begin
      m = (i < 4) ? 3'(i) : 3'(i + 2);
      set_mode(m[2], m[1], m[0]);
      code = m[2] ? 3'h0 : !m[1] ? split_status_pkg::FREQ_CONV
             : m[0] ? split_status_pkg::FREQ_66 : split_status_pkg::FREQ_133;
      rd(8'h80, {7'h0, code, 22'h0}, "clock code");
      check("cpl_id mixed", {16'h0, bus, 5'h09, FN}, {16'h0, cpl_id});
    end
    $display("test clock code done");
  endtask

  task automatic t_flags;
    logic [15:0] own;
    own = {bus, 5'h09, FN};
    set_mode(1'b0, 1'b0, 1'b0);
    i_cfg_requester.pulse(3'b111, own);
    rd(8'h80, 32'h0030_0000, "flags set");
    wr(8'h80, 32'hFFFF_FFFF, 4'hB);
    rd(8'h80, 32'h0030_0000, "clear without lane");
    wr(8'h80, 32'h0, 4'hF);
    rd(8'h80, 32'h0030_0000, "write zero");
    wr(8'h80, 32'h0010_0000, 4'hF);
    rd(8'h80, 32'h0020_0000, "clear overrun");
    fork
      i_cfg_requester.pulse(3'b010, own);
      wr(8'h80, 32'h0010_0000, 4'h4);
    join
    rd(8'h80, 32'h0030_0000, "set beats clear");
    wr(8'h80, 32'hFFFF_FFFF, 4'hF);
    rd(8'h80, 32'h0, "clear all");
    set_mode(1'b1, 1'b0, 1'b0);
    i_cfg_requester.pulse(3'b001, own ^ 16'h0001);
    rd(8'h80, 32'h0, "foreign completion");
    i_cfg_requester.pulse(3'b001, own);
    rd(8'h80, 32'h0008_0000, "own completion");
    wr(8'h80, 32'h0008_0000, 4'h4);
    rd(8'h80, 32'h0, "clear unexpected");
    i_cfg_requester.pulse(3'b001, own);
    set_mode(1'b0, 1'b0, 1'b0);
    rd(8'h80, 32'h0, "unexpected forward");
    $display("test flags done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // tests need well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      $display("timeout after %0d cycles", cycles);
      fails++;
      conclude;
    end
  end

  initial begin
    rst_n = 1'b0;
    rev = 1'b0;
    pcix = 1'b0;
    m66 = 1'b0;
    bus = 8'h3C;
    repeat (4) @(negedge clk);
    check("cpl_id in reset", 32'h0000_00F8, {16'h0, cpl_id});
    check("rvalid in reset", 32'h0, {31'h0, rvalid});
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset;
    t_capture;
    t_freq;
    t_flags;
    conclude;
  end
endmodule
